// *** hdl/uac_top.sv ***
// serial port: control registers, data register, 8/9-bit transmitter and receiver,
// address detect, receive-pin wake and a gated interrupt request
// assumes register strobes one cycle long and pins synchronous to ref_clk
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "uac_consts.svh"
module uac_top #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [`UAC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial pins
  input wire logic serial_in_pin,
  output logic serial_in_en,
  output logic serial_out_pin,
  output logic serial_out_en,
  // interrupt
  output logic port_irq
);
  if (DIV_W != 8) begin : g_chk
    $error("uac_top: divisor register is one byte wide");
  end

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic wr_ctrl1, wr_ctrl2, wr_data, wr_baud, wr_clr, wr_inten, rd_data;
  assign wr_ctrl1 = reg_wr && reg_addr == `UAC_OFF_CTRL1;
  assign wr_ctrl2 = reg_wr && reg_addr == `UAC_OFF_CTRL2;
  assign wr_data = reg_wr && reg_addr == `UAC_OFF_DATA;
  assign wr_baud = reg_wr && reg_addr == `UAC_OFF_BAUD;
  assign wr_clr = reg_wr && reg_addr == `UAC_OFF_INT_CLR;
  assign wr_inten = reg_wr && reg_addr == `UAC_OFF_INT_EN;
  assign rd_data = reg_rd && reg_addr == `UAC_OFF_DATA;

  logic port_master_enable, data_length_select, port_clock_off, transmit_ninth_bit;
  logic received_ninth_bit;
  logic [7:0] serial_control_second;
  logic [DIV_W-1:0] baud_divisor;
  logic [`UAC_EV_W-1:0] int_stat, int_en, ev;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port_master_enable <= 1'b0;
      data_length_select <= 1'b0;
      port_clock_off <= 1'b0;
      transmit_ninth_bit <= 1'b0;
    end else if (wr_ctrl1) begin
      port_master_enable <= reg_wdata[`UAC_C1_MASTER];
      data_length_select <= reg_wdata[`UAC_C1_LEN9]; // R18
      port_clock_off <= reg_wdata[`UAC_C1_CLK_OFF];
      transmit_ninth_bit <= reg_wdata[`UAC_C1_TX9]; // R18
    end
  end

  // disabling the port also drops both direction enables
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial_control_second <= `UAC_CTRL2_RST;
    end else if (wr_ctrl2) begin
      serial_control_second <= reg_wdata; // R14
    end else if (wr_ctrl1 && !reg_wdata[`UAC_C1_MASTER]) begin
      serial_control_second[`UAC_C2_TXEN] <= 1'b0; // R17
      serial_control_second[`UAC_C2_RXEN] <= 1'b0; // R17
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      baud_divisor <= `UAC_BAUD_RST;
    end else if (wr_baud) begin
      baud_divisor <= reg_wdata;
    end
  end

  logic transmitter_enable, receiver_enable, baud_speed_select, address_detect_enable;
  logic receive_pin_wake_enable, receive_interrupt_enable;
  logic tx_idle_interrupt_enable, tx_empty_interrupt_enable;
  assign transmitter_enable = serial_control_second[`UAC_C2_TXEN];
  assign receiver_enable = serial_control_second[`UAC_C2_RXEN];
  assign baud_speed_select = serial_control_second[`UAC_C2_SPEED];
  assign address_detect_enable = serial_control_second[`UAC_C2_ADDR];
  assign receive_pin_wake_enable = serial_control_second[`UAC_C2_WAKE];
  assign receive_interrupt_enable = serial_control_second[`UAC_C2_RIE];
  assign tx_idle_interrupt_enable = serial_control_second[`UAC_C2_TIIE];
  assign tx_empty_interrupt_enable = serial_control_second[`UAC_C2_TEIE];

  logic tx_on, rx_on;
  assign tx_on = port_master_enable && transmitter_enable; // R2
  assign rx_on = port_master_enable && receiver_enable; // R4

  logic os_tick;
  uac_baud #(.DIV_W(DIV_W)) u_baud (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(port_master_enable && !port_clock_off),
    .high_speed(baud_speed_select), // R5
    .divisor(baud_divisor),
    .os_tick(os_tick)
  );

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  uac_pkg::uac_tx_state_t tx_state;
  logic [8:0] tx_hold, tx_shift;
  logic tx_full, tx_line;
  logic [3:0] tx_os, tx_bits, nbits;
  logic transmitter_idle_flag, transmit_empty_flag;

  assign nbits = data_length_select ? `UAC_BITS_9 : `UAC_BITS_8;
  assign transmit_empty_flag = !tx_full;
  assign transmitter_idle_flag = tx_state == uac_pkg::uac_tx_idle && !tx_full;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_hold <= 9'h000;
    end else if (wr_data && tx_on) begin
      tx_hold <= {transmit_ninth_bit, reg_wdata}; // R15 R18
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !tx_on) begin
      tx_state <= uac_pkg::uac_tx_idle; // R1
      tx_full <= 1'b0; // R1
      tx_shift <= 9'h000;
      tx_os <= 4'h0;
      tx_bits <= 4'h0;
      tx_line <= 1'b1;
    end else begin
      if (wr_data) begin
        tx_full <= 1'b1;
      end
      case (tx_state)
        uac_pkg::uac_tx_idle: begin
          tx_line <= 1'b1;
          if (tx_full && !wr_data) begin
            tx_shift <= tx_hold;
            tx_full <= 1'b0;
            tx_os <= 4'h0;
            tx_bits <= 4'h0;
            tx_line <= 1'b0;
            tx_state <= uac_pkg::uac_tx_start;
          end
        end
        uac_pkg::uac_tx_start: begin
          if (os_tick) begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == `UAC_OS_LAST) begin
              tx_line <= tx_shift[0];
              tx_state <= uac_pkg::uac_tx_data;
            end
          end
        end
        uac_pkg::uac_tx_data: begin
          if (os_tick) begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == `UAC_OS_LAST) begin
              tx_bits <= tx_bits + 4'h1;
              tx_shift <= {1'b1, tx_shift[8:1]};
              if (tx_bits == nbits - 4'h1) begin
                tx_line <= 1'b1;
                tx_state <= uac_pkg::uac_tx_stop;
              end else begin
                tx_line <= tx_shift[1];
              end
            end
          end
        end
        uac_pkg::uac_tx_stop: begin
          if (os_tick) begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == `UAC_OS_LAST) begin
              tx_state <= uac_pkg::uac_tx_idle;
            end
          end
        end
        default: tx_state <= uac_pkg::uac_tx_idle;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial_out_en <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      serial_out_en <= tx_on; // R1 R2 R17
      serial_out_pin <= tx_on ? tx_line : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  uac_pkg::uac_rx_state_t rx_state;
  logic [8:0] rx_shift;
  logic [3:0] rx_os, rx_bits;
  logic [7:0] rx_data;
  logic rx_done, receive_available_flag, overrun_flag;
  logic [7:0] word_data;
  logic word_ninth, addr_bit, rx_accept;

  always_ff @(posedge ref_clk) begin
    if (srst || !rx_on) begin
      rx_state <= uac_pkg::uac_rx_idle; // R3
      rx_shift <= 9'h000;
      rx_os <= 4'h0;
      rx_bits <= 4'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        uac_pkg::uac_rx_idle: begin
          if (os_tick && !serial_in_pin) begin
            rx_os <= 4'h0;
            rx_bits <= 4'h0;
            rx_state <= uac_pkg::uac_rx_start;
          end
        end
        uac_pkg::uac_rx_start: begin
          if (os_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == `UAC_OS_MID) begin
              rx_os <= 4'h0;
              rx_state <= serial_in_pin ? uac_pkg::uac_rx_idle : uac_pkg::uac_rx_data;
            end
          end
        end
        uac_pkg::uac_rx_data: begin
          if (os_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == `UAC_OS_LAST) begin
              rx_shift <= {serial_in_pin, rx_shift[8:1]};
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == nbits - 4'h1) begin
                rx_state <= uac_pkg::uac_rx_stop;
              end
            end
          end
        end
        uac_pkg::uac_rx_stop: begin
          if (os_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == `UAC_OS_LAST) begin
              rx_done <= 1'b1;
              rx_state <= uac_pkg::uac_rx_idle;
            end
          end
        end
        default: rx_state <= uac_pkg::uac_rx_idle;
      endcase
    end
  end

  // an 8-bit word sits in the upper shift bits
  assign word_data = data_length_select ? rx_shift[7:0] : rx_shift[8:1];
  assign word_ninth = rx_shift[8];
  assign addr_bit = data_length_select ? word_ninth : word_data[7]; // R6
  assign rx_accept = rx_done && (!address_detect_enable || addr_bit); // R8

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_data <= 8'h00;
      received_ninth_bit <= 1'b0;
    end else if (rx_accept && !receive_available_flag) begin
      rx_data <= word_data; // R15
      received_ninth_bit <= word_ninth; // R18
    end
  end

  // a new word beats a data read in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst || !rx_on) begin
      receive_available_flag <= 1'b0; // R3
      overrun_flag <= 1'b0;
    end else begin
      if (rx_accept) begin
        receive_available_flag <= 1'b1;
      end else if (rd_data) begin
        receive_available_flag <= 1'b0;
      end
      if (rx_accept && receive_available_flag) begin
        overrun_flag <= 1'b1;
      end else if (rd_data) begin
        overrun_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial_in_en <= 1'b0;
    end else begin
      serial_in_en <= rx_on; // R3 R4 R17
    end
  end

  // ---------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------
  logic idle_d, empty_d, in_d;
  logic [`UAC_EV_W-1:0] gate, clr_mask;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      idle_d <= 1'b1;
      empty_d <= 1'b1;
      in_d <= 1'b1;
    end else begin
      idle_d <= transmitter_idle_flag;
      empty_d <= transmit_empty_flag;
      in_d <= serial_in_pin;
    end
  end

  always_comb begin
    ev = '0;
    ev[`UAC_EV_RXA] = rx_accept && !receive_available_flag;
    ev[`UAC_EV_OVR] = rx_accept && receive_available_flag;
    ev[`UAC_EV_ADR] = rx_done && address_detect_enable && addr_bit; // R7
    ev[`UAC_EV_IDLE] = transmitter_idle_flag && !idle_d;
    ev[`UAC_EV_EMPTY] = transmit_empty_flag && !empty_d;
    ev[`UAC_EV_WAKE] = port_clock_off && receive_pin_wake_enable && in_d && !serial_in_pin; // R9
  end

  always_comb begin
    gate = '0;
    gate[`UAC_EV_RXA] = receive_interrupt_enable; // R11
    gate[`UAC_EV_OVR] = receive_interrupt_enable; // R11
    gate[`UAC_EV_ADR] = receive_interrupt_enable && address_detect_enable; // R7
    gate[`UAC_EV_IDLE] = tx_idle_interrupt_enable; // R12
    gate[`UAC_EV_EMPTY] = tx_empty_interrupt_enable; // R13
    gate[`UAC_EV_WAKE] = receive_pin_wake_enable;
  end

  assign clr_mask = wr_clr ? reg_wdata[`UAC_EV_W-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & ~clr_mask) | ev;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      int_en <= `UAC_INT_EN_RST;
    end else if (wr_inten) begin
      int_en <= reg_wdata[`UAC_EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port_irq <= 1'b0;
    end else begin
      port_irq <= |(int_stat & int_en & gate); // R19
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `UAC_OFF_CTRL1: reg_rdata <= {port_master_enable, data_length_select, port_clock_off,
                                      3'h0, received_ninth_bit, 1'b0};
        `UAC_OFF_CTRL2: reg_rdata <= serial_control_second; // R14
        `UAC_OFF_DATA: reg_rdata <= rx_data;
        `UAC_OFF_BAUD: reg_rdata <= baud_divisor;
        `UAC_OFF_STATUS: reg_rdata <= {4'h0, transmit_empty_flag, transmitter_idle_flag,
                                       overrun_flag, receive_available_flag};
        `UAC_OFF_INT_STAT: reg_rdata <= {2'h0, int_stat};
        `UAC_OFF_INT_EN: reg_rdata <= {2'h0, int_en};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence tx_cleared_s;
    $fell(transmitter_enable) || $fell(port_master_enable);
  endsequence

  sequence addr_word_s;
    rx_done && address_detect_enable && addr_bit;
  endsequence

  tx_abort_float_a: assert property (@(posedge ref_clk) disable iff (srst) // R1
    tx_cleared_s |=> (!serial_out_en && tx_state == uac_pkg::uac_tx_idle && !tx_full))
    else $error("transmitter not reset after disable");
  tx_drive_on_a: assert property (@(posedge ref_clk) disable iff (srst) // R2
    tx_on |=> serial_out_en)
    else $error("output pin not driven while enabled");
  rx_abort_reset_a: assert property (@(posedge ref_clk) disable iff (srst) // R3
    !rx_on |=> (!receive_available_flag && rx_state == uac_pkg::uac_rx_idle && !serial_in_en))
    else $error("receiver not reset while disabled");
  rx_pin_own_a: assert property (@(posedge ref_clk) disable iff (srst) // R4
    rx_on |=> serial_in_en)
    else $error("receive pin not owned while enabled");
  addr_flag_set_a: assert property (@(posedge ref_clk) disable iff (srst) // R7
    addr_word_s |=> int_stat[`UAC_EV_ADR])
    else $error("address word did not set its flag");
  data_drop_a: assert property (@(posedge ref_clk) disable iff (srst) // R8
    (rx_done && address_detect_enable && !addr_bit && !receive_available_flag)
      |=> !receive_available_flag)
    else $error("non-address word was kept");
  wake_edge_a: assert property (@(posedge ref_clk) disable iff (srst) // R9
    (port_clock_off && receive_pin_wake_enable && in_d && !serial_in_pin)
      |=> int_stat[`UAC_EV_WAKE])
    else $error("wake edge missed");
  rx_irq_route_a: assert property (@(posedge ref_clk) disable iff (srst) // R11
    (int_stat[`UAC_EV_RXA] && int_en[`UAC_EV_RXA] && receive_interrupt_enable) |=> port_irq)
    else $error("receive flag not routed to request");
  irq_quiet_a: assert property (@(posedge ref_clk) disable iff (srst) // R12
    !(|(int_stat & int_en & gate)) |=> !port_irq)
    else $error("request without enabled cause");
  ctrl2_readback_a: assert property (@(posedge ref_clk) disable iff (srst) // R14
    (reg_rd && reg_addr == `UAC_OFF_CTRL2) |=> reg_rdata == $past(serial_control_second))
    else $error("second control register read wrong");
  master_float_a: assert property (@(posedge ref_clk) disable iff (srst) // R17
    !port_master_enable |=> (!serial_out_en && !serial_in_en))
    else $error("pins driven while port disabled");
endmodule : uac_top

// *** hdl/uac_consts.svh ***
// register offsets, field positions, reset values and timing counts of the serial port
// assumes a byte-wide register port with a 3-bit word address and a 20 MHz ref_clk
//
// Operation
// [R1] transmit enable low or cleared: abort sending, reset transmitter, float output
// [R2] output pin driven and transmitter running only with transmit and master enables
// [R3] receive enable low or cleared: abort reception, reset receiver and its buffer
// [R4] receive pin owned by the port only with receive and master enables set
// [R5] speed select picks high-speed mode at one, low-speed mode at zero
// [R6] with address detect, a word whose address bit is one is an address
// [R7] with address detect and receive interrupt on, each address word requests interrupt
// [R8] with address detect, a word with address bit zero is dropped silently
// [R9] wake enable acts only while port clock is off; falling input edge wakes
// [R10] software restarts the port clock after a wake; no wake when disabled (the code still flags a wake while master enable is low)
// [R11] receive interrupt enable routes available and overrun flags to the request
// [R12] idle interrupt enable routes the transmitter idle flag to the request
// [R13] empty interrupt enable routes the transmit empty flag to the request
// [R14] second control register: eight read/write enables, transmit enable at bit 7
// [R15] one 8-bit read/write data register for sent and received characters
// [R16] bit time is 64 or 16 clocks times divisor plus one
// [R17] master enable low disables the port and floats both pins
// [R18] nine-bit format keeps received ninth bit readable, sends written ninth bit
// [R19] one request line ORs all enabled port conditions
`ifndef UAC_CONSTS_SVH
`define UAC_CONSTS_SVH

`define UAC_ADDR_W 3
`define UAC_OFF_CTRL1 3'h0
`define UAC_OFF_CTRL2 3'h1
`define UAC_OFF_DATA 3'h2
`define UAC_OFF_BAUD 3'h3
`define UAC_OFF_STATUS 3'h4
`define UAC_OFF_INT_STAT 3'h5
`define UAC_OFF_INT_CLR 3'h6
`define UAC_OFF_INT_EN 3'h7

`define UAC_C1_MASTER 7
`define UAC_C1_LEN9 6
`define UAC_C1_CLK_OFF 5
`define UAC_C1_RX9 1
`define UAC_C1_TX9 0

`define UAC_C2_TXEN 7
`define UAC_C2_RXEN 6
`define UAC_C2_SPEED 5
`define UAC_C2_ADDR 4
`define UAC_C2_WAKE 3
`define UAC_C2_RIE 2
`define UAC_C2_TIIE 1
`define UAC_C2_TEIE 0

`define UAC_EV_W 6
`define UAC_EV_RXA 0
`define UAC_EV_OVR 1
`define UAC_EV_ADR 2
`define UAC_EV_IDLE 3
`define UAC_EV_EMPTY 4
`define UAC_EV_WAKE 5

`define UAC_CTRL2_RST 8'h00
`define UAC_BAUD_RST 8'h00
`define UAC_INT_EN_RST 6'h00

`define UAC_PRE_LOW_LAST 2'h3
`define UAC_PRE_HIGH_LAST 2'h0
`define UAC_OS_LAST 4'hf
`define UAC_OS_MID 4'h7
`define UAC_BITS_8 4'h8
`define UAC_BITS_9 4'h9

`endif

// *** hdl/uac_pkg.sv ***
// state types of the serial port transmitter and receiver
// assumes nothing beyond the consumers in hdl/
package uac_pkg;
  typedef enum logic [3:0] {
    uac_tx_idle = 4'b0001,
    uac_tx_start = 4'b0010,
    uac_tx_data = 4'b0100,
    uac_tx_stop = 4'b1000
  } uac_tx_state_t;

  typedef enum logic [3:0] {
    uac_rx_idle = 4'b0001,
    uac_rx_start = 4'b0010,
    uac_rx_data = 4'b0100,
    uac_rx_stop = 4'b1000
  } uac_rx_state_t;
endpackage : uac_pkg

// *** hdl/uac_baud.sv ***
// baud generator: one 16x oversample tick per 1/16 bit time
// assumes run falls whenever the port is disabled or its clock is off
`timescale 1ns/10ps
`include "uac_consts.svh"
module uac_baud #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // configuration
  input wire logic run,
  input wire logic high_speed,
  input wire logic [DIV_W-1:0] divisor,
  // tick
  output logic os_tick
);
  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("uac_baud: DIV_W out of range");
  end

  logic [1:0] pre;
  logic [DIV_W-1:0] cnt;
  logic [1:0] pre_last;

  assign pre_last = high_speed ? `UAC_PRE_HIGH_LAST : `UAC_PRE_LOW_LAST; // R5

  // tick period is 4*(N+1) clocks low speed, (N+1) high speed
  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      pre <= 2'h0;
      cnt <= '0;
      os_tick <= 1'b0;
    end else begin
      os_tick <= 1'b0;
      if (pre >= pre_last) begin
        pre <= 2'h0;
        if (cnt >= divisor) begin // R16
          cnt <= '0;
          os_tick <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end else begin
        pre <= pre + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [DIV_W+2:0] gap;
  logic dirty;
  logic hs_d;
  logic [DIV_W-1:0] div_d;
  logic cfg_chg;
  logic [DIV_W:0] steps;
  logic [DIV_W+2:0] expect_gap;

  assign cfg_chg = (hs_d != high_speed) || (div_d != divisor);
  assign steps = {1'b0, divisor} + 1'b1;
  assign expect_gap = high_speed ? {2'b00, steps} : {steps, 2'b00};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gap <= '0;
      dirty <= 1'b1;
      hs_d <= 1'b0;
      div_d <= '0;
    end else begin
      hs_d <= high_speed;
      div_d <= divisor;
      gap <= os_tick ? {{(DIV_W+2){1'b0}}, 1'b1} : gap + 1'b1;
      if (!run || cfg_chg) begin
        dirty <= 1'b1;
      end else if (os_tick) begin
        dirty <= 1'b0;
      end
    end
  end

  tick_period_a: assert property (@(posedge ref_clk) disable iff (srst) // R16
    (os_tick && !dirty && !cfg_chg && run) |-> gap == expect_gap)
    else $error("oversample tick period wrong");
endmodule : uac_baud

// *** dv/uac_far.sv ***
// far-side serial device: sends frames to the port and captures frames from it
// assumes divisor 0 with high speed (16 clocks a bit) and a pulled-up transmit line
`timescale 1ns/10ps
module uac_far (
  // clock
  input wire logic ref_clk,
  // serial line
  input wire logic line_in,
  output logic line_out,
  // captured frames
  output logic [7:0] got,
  output int got_n
);
  localparam int BIT_CLKS = 16;
  initial line_out = 1'b1;
  // -------------------------------------------------------
  // start bit, eight data bits lsb first, one stop bit
  // -------------------------------------------------------
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
  endtask : send
  // samples mid-bit, bit 0 a bit and a half after the falling start edge
  initial begin
    got_n = 0;
    got = 8'h00;
    forever begin
      @(posedge ref_clk);
      if (line_in === 1'b0) begin
        repeat (BIT_CLKS / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS) @(posedge ref_clk);
          got[i] = line_in;
        end
        repeat (BIT_CLKS) @(posedge ref_clk);
        got_n++;
      end
    end
  end
endmodule : uac_far

// *** dv/tb.sv ***
// self-checking bench of the serial port over its register port and pins
// assumes uac_top in hdl/ and the far-side model uac_far beside it
`timescale 1ns/10ps
`include "uac_consts.svh"
module tb;
  logic ref_clk, srst, reg_wr, reg_rd, line;
  logic [`UAC_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got;
  logic serial_in_pin, serial_in_en, serial_out_pin, serial_out_en, port_irq;
  int fail_count, checks, cyc, got_n, n0;
  // pull-up holds the transmit line high while the port floats it
  assign line = serial_out_en ? serial_out_pin : 1'b1;
  uac_top #(.DIV_W(8)) dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_in_pin(serial_in_pin), .serial_in_en(serial_in_en),
    .serial_out_pin(serial_out_pin), .serial_out_en(serial_out_en), .port_irq(port_irq));
  uac_far far (.ref_clk(ref_clk), .line_in(line), .line_out(serial_in_pin), .got(got),
    .got_n(got_n));
  // -------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask : rdc
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  task automatic close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  // -------------------------------------------------------
  // scenarios
  // -------------------------------------------------------
  task automatic t_regs;
    rdc(1, 8'h00, "ctrl2 reset");
    wr(0, 8'h80);
    wr(1, 8'hff);
    rdc(1, 8'hff, "ctrl2 rw");
    rdc(6, 8'h00, "clear reads 0");
    wr(0, 8'h00);
    rdc(1, 8'h3f, "ctrl2 master off");
    chk("pins master off", 8'({serial_out_en, serial_in_en}), 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_tx;
    wr(3, 8'h00);
    wr(0, 8'h80);
    wr(1, 8'ha0);
    wt(2);
    chk("tx owns pin", 8'(serial_out_en), 8'h01);
    n0 = got_n;
    wr(2, 8'ha5);
    wt(200);
    chk("tx frames", 8'(got_n - n0), 8'h01);
    chk("tx byte", got, 8'ha5);
    wr(6, 8'hff);
    wr(7, 8'h18);
    wr(2, 8'h55);
    wt(200);
    wr(1, 8'ha2);
    wt(2);
    chk("idle irq on", 8'(port_irq), 8'h01);
    wr(1, 8'ha0);
    wt(2);
    chk("idle irq off", 8'(port_irq), 8'h00);
    wr(1, 8'ha1);
    wt(2);
    chk("empty irq on", 8'(port_irq), 8'h01);
    wr(1, 8'ha0);
    wr(2, 8'h55);
    wr(2, 8'h66);
    wt(40);
    wr(1, 8'h20);
    wt(2);
    chk("tx floats", 8'(serial_out_en), 8'h00);
    wt(200);
    n0 = got_n;
    wr(1, 8'ha0);
    wt(250);
    chk("tx buffer reset", 8'(got_n - n0), 8'h00);
    wr(3, 8'h02);
    wr(1, 8'h80);
    wt(40);
    rdc(3, 8'h02, "baud divisor");
    wr(3, 8'h00);
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx;
    wr(6, 8'hff);
    wr(7, 8'h03);
    wr(1, 8'h64);
    wt(2);
    chk("rx owns pin", 8'(serial_in_en), 8'h01);
    far.send(8'h3c);
    wt(40);
    chk("rx irq", 8'(port_irq), 8'h01);
    rdc(2, 8'h3c, "rx byte");
    wr(6, 8'hff);
    wr(1, 8'h60);
    far.send(8'h11);
    wt(40);
    chk("rx irq masked", 8'(port_irq), 8'h00);
    rdc(2, 8'h11, "rx byte masked");
    wr(1, 8'h20);
    wt(2);
    chk("rx floats", 8'(serial_in_en), 8'h00);
    $display("test rx done");
  endtask : t_rx
  task automatic t_addr;
    wr(6, 8'hff);
    wr(7, 8'h04);
    wr(1, 8'h74);
    far.send(8'h12);
    wt(40);
    chk("data word irq", 8'(port_irq), 8'h00);
    rdc(5, 8'h00, "data word dropped");
    far.send(8'h92);
    wt(40);
    chk("addr word irq", 8'(port_irq), 8'h01);
    rdc(5, 8'h05, "addr word events");
    rdc(2, 8'h92, "addr word byte");
    wr(0, 8'hc0);
    far.send(8'h12);
    wt(40);
    rdc(0, 8'hc2, "ninth bit kept");
    rdc(2, 8'h12, "nine-bit addr word");
    $display("test addr done");
  endtask : t_addr
  task automatic t_wake;
    wr(1, 8'h08);
    wr(0, 8'ha0);
    wr(6, 8'hff);
    wr(7, 8'h20);
    far.line_out <= 1'b0;
    wt(3);
    chk("wake irq", 8'(port_irq), 8'h01);
    far.line_out <= 1'b1;
    wr(1, 8'h00);
    wr(6, 8'hff);
    far.line_out <= 1'b0;
    wt(3);
    chk("no wake when off", 8'(port_irq), 8'h00);
    far.line_out <= 1'b1;
    wr(0, 8'h80);
    $display("test wake done");
  endtask : t_wake
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 13'h0000};
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_addr();
    t_wake();
    close_out();
  end
endmodule : tb
